// ===== rtl/pmb_defines.svh
// Constants for the program map and boot configuration block
// Overview of operation
// - Secured-state bit loads only at reset; later security changes wait for next reset.
// - Software writes to secured-state bit never alter real flash security.
// - Map-select 0 decodes program space with the internal map.
// - Map-select 1 uses external map; writes ignored if secured-state was 0 at reset.
// - After reset chip selects zero and one act as program and data strobes.
// - Bus-width strap high at reset in external boot makes four GPIO pins address bits 19..16.
// - Internal boot: boot vector 02_0000, watchdog vector 02_0002 in boot flash.
// - External 16-bit boot: external RAM at 00_0000, watchdog vector 00_0002.
// - External 20-bit boot: external memory overlays boot flash window and boots.
// - Two independent 128KB program flash blocks.
// - With flash security enabled, external boot mode 1 is never entered.
// - Bus-width strap sampled at boot: grounded reads 0, tied high reads 1.
// - Secured-state 0 with external boot strap high configures as internal boot.
// - After reset secured-state bit changes do not alter the program map.
`ifndef PMB_DEFINES_SVH
`define PMB_DEFINES_SVH

`define PMB_AW            21
`define PMB_BOOT_INT      21'h02_0000
`define PMB_WDOG_INT      21'h02_0002
`define PMB_BOOT_EXT16    21'h00_0000
`define PMB_WDOG_EXT16    21'h00_0002
`define PMB_FLASH0_BASE   21'h00_0000
`define PMB_FLASH0_END    21'h00_ffff
`define PMB_FLASH1_BASE   21'h01_0000
`define PMB_FLASH1_END    21'h01_ffff
`define PMB_BFLASH_BASE   21'h02_0000
`define PMB_BFLASH_END    21'h02_1fff
`define PMB_PRAM_BASE     21'h02_f800
`define PMB_PRAM_END      21'h02_ffff
`define PMB_HIGH_BASE     21'h10_0000
`define PMB_HIGH_END      21'h1f_ffff
`define PMB_LIM16         21'h00_ffff
`define PMB_LIM20         21'h0f_ffff

`endif

// ===== rtl/pmb_pkg.sv
// Types for the program map and boot configuration block
package pmb_pkg;
    typedef enum logic [4:0] {
        PMB_TGT_NONE   = 5'h01,
        PMB_TGT_FLASH0 = 5'h02,
        PMB_TGT_FLASH1 = 5'h04,
        PMB_TGT_BFLASH = 5'h08,
        PMB_TGT_PRAM   = 5'h10
    } pmb_int_tgt_t;

    typedef struct packed {
        logic         ext;      // Access goes out on external interface
        pmb_int_tgt_t tgt;      // Internal target when not external
        logic         reach;    // External address reachable with reset pins
    } pmb_route_t;

    typedef enum logic [2:0] {
        PMB_ST_RESET = 3'h1,
        PMB_ST_LATCH = 3'h2,
        PMB_ST_RUN   = 3'h4
    } pmb_state_t;
endpackage

// ===== rtl/pmb_decode.sv
// Program-space address decoder for one map configuration
`timescale 1ns/1ps
`include "pmb_defines.svh"
module pmb_decode
    import pmb_pkg::*;
(
    input  wire logic [20:0] addr_i,       // Program word address
    input  wire logic        ext_map_i,    // External map active
    input  wire logic        wide_bus_i,   // 20-bit bus
    output pmb_route_t       route_o       // Decode result
);
    // Map decode; reserved gaps map to no target
    always_comb begin
        route_o.ext   = 1'b0;
        route_o.tgt   = PMB_TGT_NONE;
        route_o.reach = 1'b0;
        if (addr_i >= `PMB_HIGH_BASE) begin
            route_o.ext   = 1'b1;
            route_o.reach = 1'b0;
        end else if (!ext_map_i) begin
            if (addr_i <= `PMB_FLASH0_END)
                route_o.tgt = PMB_TGT_FLASH0;
            else if (addr_i <= `PMB_FLASH1_END)
                route_o.tgt = PMB_TGT_FLASH1;
            else if (addr_i <= `PMB_BFLASH_END)
                route_o.tgt = PMB_TGT_BFLASH;
            else if (addr_i >= `PMB_PRAM_BASE && addr_i <= `PMB_PRAM_END)
                route_o.tgt = PMB_TGT_PRAM;
        end else begin
            if (addr_i <= `PMB_FLASH0_END) begin
                route_o.ext   = 1'b1;
                route_o.reach = 1'b1;
            end else if (addr_i <= `PMB_FLASH1_END)
                route_o.tgt = PMB_TGT_FLASH1;
            else if (addr_i <= `PMB_BFLASH_END) begin
                if (wide_bus_i) begin
                    route_o.ext   = 1'b1;
                    route_o.reach = 1'b1;
                end else
                    route_o.tgt = PMB_TGT_BFLASH;
            end else if (addr_i >= `PMB_PRAM_BASE && addr_i <= `PMB_PRAM_END)
                route_o.tgt = PMB_TGT_PRAM;
        end
    end
endmodule

// ===== rtl/pmb_boot_config.sv
// Top of the program map and boot configuration block
`timescale 1ns/1ps
`include "pmb_defines.svh"
module pmb_boot_config
    import pmb_pkg::*;
(
    input  wire logic        core_clk_i,          // System clock, 40 MHz
    input  wire logic        rst_i,               // Synchronous reset, active high
    input  wire logic        flash_secure_i,      // Flash security enabled (pin domain)
    input  wire logic        external_boot_strap_i, // Boot strap pin
    input  wire logic        bus_width_strap_i,   // Bus width strap pin
    input  wire logic        map_select_wr_i,     // Software write strobe for map-select
    input  wire logic        map_select_bit_i,    // Value to write to map-select
    input  wire logic        secured_state_wr_i,  // Software write strobe for secured-state
    input  wire logic        secured_state_bit_i, // Value to write to secured-state
    input  wire logic [20:0] fetch_addr_i,        // Program-space address to decode
    output logic             map_select_bit_o,    // Current map-select bit
    output logic             secured_state_bit_o, // Current secured-state bit
    output logic             cfg_valid_o,         // Reset configuration captured
    output logic             wide_bus_o,          // Address bits 19..16 on GPIO pins
    output logic             cs_legacy_o,         // Chip selects act as program/data strobes
    output logic [20:0]      boot_vector_o,       // Boot fetch address
    output logic [20:0]      wdog_vector_o,       // Watchdog reset vector address
    output logic [20:0]      ext_addr_limit_o,    // Highest reachable external address
    output logic             flash_secure_o,      // Real flash security (not software)
    output pmb_route_t       route_o              // Registered decode of fetch address
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage is read only by the second
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] next_pin_s1;
    logic [2:0] next_pin_s2;

    always_comb begin
        next_pin_s1 = {flash_secure_i, external_boot_strap_i, bus_width_strap_i};
        next_pin_s2 = pin_s1;
    end

    always_ff @(posedge core_clk_i) begin
        pin_s1 <= next_pin_s1;
        pin_s2 <= next_pin_s2;
    end

    logic sec_sync;
    logic boot_sync;
    logic width_sync;
    assign sec_sync   = pin_s2[2];
    assign boot_sync  = pin_s2[1];
    assign width_sync = pin_s2[0];

    ////////////////////////////////////////////////////////////////////////
    // Configuration state: waits for pins to settle after release, then latches
    pmb_state_t state;
    pmb_state_t next_state;
    logic       ma;
    logic       mb;
    logic       mb_at_reset;
    logic       wide;
    logic       next_ma;
    logic       next_mb;
    logic       next_mb_at_reset;
    logic       next_wide;

    // Capture happens two clocks after release so the synchronisers carry pin levels
    always_comb begin
        next_state       = state;
        next_ma          = ma;
        next_mb          = mb;
        next_mb_at_reset = mb_at_reset;
        next_wide        = wide;
        case (state)
            PMB_ST_RESET: begin
                next_state = PMB_ST_LATCH;
            end
            PMB_ST_LATCH: begin
                next_state       = PMB_ST_RUN;
                next_mb          = ~sec_sync;
                next_mb_at_reset = ~sec_sync;
                next_ma          = boot_sync & ~sec_sync;
                // Internal boot always keeps the 16-line bus; the strap only counts in external boot
                next_wide        = width_sync & boot_sync & ~sec_sync;
            end
            PMB_ST_RUN: begin
                if (map_select_wr_i && mb_at_reset)
                    next_ma = map_select_bit_i;
                if (secured_state_wr_i)
                    next_mb = secured_state_bit_i;
            end
            default: begin
                next_state = PMB_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state       <= PMB_ST_RESET;
            ma          <= 1'b0;
            mb          <= 1'b0;
            mb_at_reset <= 1'b0;
            wide        <= 1'b0;
        end else begin
            state       <= next_state;
            ma          <= next_ma;
            mb          <= next_mb;
            mb_at_reset <= next_mb_at_reset;
            wide        <= next_wide;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vectors and pin configuration; registered, fixed by reset-time mode
    logic        boot_ext;
    logic [20:0] next_boot_vec;
    logic [20:0] next_wdog_vec;
    logic [20:0] next_limit;

    // Boot mode is the map-select value as latched, not later writes
    logic boot_ext_q;
    logic next_boot_ext_q;
    assign boot_ext = (state == PMB_ST_LATCH) ? (boot_sync & ~sec_sync) : boot_ext_q;

    always_comb begin
        next_boot_ext_q = boot_ext;
        if (boot_ext && !((state == PMB_ST_LATCH) ? width_sync : wide)) begin
            next_boot_vec = `PMB_BOOT_EXT16;
            next_wdog_vec = `PMB_WDOG_EXT16;
        end else begin
            next_boot_vec = `PMB_BOOT_INT;
            next_wdog_vec = `PMB_WDOG_INT;
        end
        // Pins above bit 19 stay GPIO until software reassigns them
        next_limit = wide ? `PMB_LIM20 : `PMB_LIM16;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            boot_ext_q       <= 1'b0;
            boot_vector_o    <= `PMB_BOOT_INT;
            wdog_vector_o    <= `PMB_WDOG_INT;
            ext_addr_limit_o <= `PMB_LIM16;
        end else begin
            boot_ext_q       <= next_boot_ext_q;
            boot_vector_o    <= next_boot_vec;
            wdog_vector_o    <= next_wdog_vec;
            ext_addr_limit_o <= next_limit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode against the live map-select bit
    pmb_route_t dec_route;
    pmb_route_t next_route;

    pmb_decode u_decode (
        .addr_i     (fetch_addr_i),
        .ext_map_i  (ma),
        .wide_bus_i (wide),
        .route_o    (dec_route)
    );

    // Beyond the active bus width an external access is not reachable
    always_comb begin
        next_route = dec_route;
        if (dec_route.ext && fetch_addr_i > ext_addr_limit_o)
            next_route.reach = 1'b0;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i)
            route_o <= '{ext: 1'b0, tgt: PMB_TGT_NONE, reach: 1'b0};
        else
            route_o <= next_route;
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain outputs
    assign map_select_bit_o    = ma;
    assign secured_state_bit_o = mb;
    assign cfg_valid_o         = (state == PMB_ST_RUN);
    assign wide_bus_o          = wide;
    assign cs_legacy_o         = 1'b1;
    assign flash_secure_o      = sec_sync;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_mb_latched_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == PMB_ST_RUN && $past(state) == PMB_ST_RUN && !secured_state_wr_i
         && $past(sec_sync) != sec_sync) |=> $stable(mb))
        else $error("secured-state bit followed live flash security");
    chk_sw_mb_no_sec: assert property (@(posedge core_clk_i) disable iff (rst_i)
        secured_state_wr_i |-> flash_secure_o == sec_sync)
        else $error("software write touched flash security");
    chk_ma_locked_secure: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == PMB_ST_RUN && !mb_at_reset) |=> !ma)
        else $error("map-select changed while locked");
    chk_ma_write_takes: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == PMB_ST_RUN && mb_at_reset && map_select_wr_i) |=> ma == $past(map_select_bit_i))
        else $error("map-select write lost");
    chk_secure_no_ext: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == PMB_ST_LATCH && sec_sync) |=> !ma ##0 boot_vector_o == `PMB_BOOT_INT)
        else $error("external boot entered while secured");
    chk_ext16_vectors: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == PMB_ST_LATCH && boot_sync && !sec_sync && !width_sync)
        |=> boot_vector_o == `PMB_BOOT_EXT16 && wdog_vector_o == `PMB_WDOG_EXT16)
        else $error("external 16-bit boot vectors wrong");
    chk_int_vectors: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == PMB_ST_LATCH && !boot_sync) |=> boot_vector_o == `PMB_BOOT_INT ##1 wdog_vector_o == `PMB_WDOG_INT)
        else $error("internal boot vectors wrong");
    chk_wide_strap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == PMB_ST_LATCH) |=> wide == $past(width_sync & boot_sync & ~sec_sync)
        ##1 ext_addr_limit_o == (wide ? `PMB_LIM20 : `PMB_LIM16))
        else $error("bus width strap not applied");
    chk_reserved_none: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (fetch_addr_i > `PMB_BFLASH_END && fetch_addr_i < `PMB_PRAM_BASE) |=> !route_o.ext && route_o.tgt == PMB_TGT_NONE)
        else $error("reserved address routed");
    chk_high_unreach: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (fetch_addr_i >= `PMB_HIGH_BASE) |=> route_o.ext && !route_o.reach)
        else $error("high external region reachable at reset");
endmodule

// ===== verification/pmb_ext_mem_model.sv
// Behavioural model of the external program memory behind the external interface
`timescale 1ns/1ps
module pmb_ext_mem_model
    import pmb_pkg::*;
(
    input  wire logic        core_clk_i, // System clock
    input  wire logic [20:0] addr_i,     // Fetch address seen by the block
    input  wire pmb_route_t  route_i,    // Registered decode from the block
    output logic      [15:0] data_o,     // Read data, scrambled when selected, inverted address when not selected
    output logic             ack_o       // Memory answered this cycle
);
    logic [20:0] addr_q;

    // Align the address with the registered decode of the block
    always @(posedge core_clk_i) begin
        addr_q <= addr_i;
    end

    // Only reachable lines answer; pins above the reset width are never set up here
    always_comb begin
        ack_o  = route_i.ext & route_i.reach;
        data_o = ack_o ? (addr_q[15:0] ^ 16'h3c5a) : ~addr_q[15:0];
    end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the program map and boot configuration block
`timescale 1ns/1ps
`include "pmb_defines.svh"
module tb_top;
    import pmb_pkg::*;
    logic        core_clk_i, rst_i, sec, boot, width, ma_wr, ma_d, mb_wr, mb_d;
    logic [20:0] addr, bvec, wvec, lim;
    logic        ma_o, mb_o, cfg_o, wide_o, csl_o, fsec_o, xack;
    logic [15:0] xdata;
    pmb_route_t  route;
    int          miscompares, compares, m_ma, m_mb, m_wide, m_ext;
    logic [20:0] edges [14] = '{21'h00_0000, 21'h00_ffff, 21'h01_0000, 21'h01_ffff, 21'h02_0000, 21'h02_1fff,
        21'h02_2000, 21'h02_f7ff, 21'h02_f800, 21'h02_ffff, 21'h03_0000, 21'h0f_ffff, 21'h10_0000, 21'h1f_ffff};

    pmb_boot_config DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .flash_secure_i(sec),
        .external_boot_strap_i(boot), .bus_width_strap_i(width), .map_select_wr_i(ma_wr),
        .map_select_bit_i(ma_d), .secured_state_wr_i(mb_wr), .secured_state_bit_i(mb_d),
        .fetch_addr_i(addr), .map_select_bit_o(ma_o), .secured_state_bit_o(mb_o), .cfg_valid_o(cfg_o),
        .wide_bus_o(wide_o), .cs_legacy_o(csl_o), .boot_vector_o(bvec), .wdog_vector_o(wvec),
        .ext_addr_limit_o(lim), .flash_secure_o(fsec_o), .route_o(route));
    pmb_ext_mem_model XMEM (.core_clk_i(core_clk_i), .addr_i(addr), .route_i(route), .data_o(xdata), .ack_o(xack));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Inputs always move a fixed 1 ns after the rising edge
    task automatic tick();
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic close_out();
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_val(input string n, input logic [20:0] e, input logic [20:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Expected decode worked out from the map tables, not from the design
    task automatic cmp_route(input logic [20:0] a);
        logic         e_ext;
        pmb_int_tgt_t e_tgt;
        e_ext = 1'b0;
        e_tgt = PMB_TGT_NONE;
        if (a >= `PMB_HIGH_BASE) e_ext = 1'b1;
        else if (a <= `PMB_FLASH0_END) begin
            e_ext = (m_ma != 0);
            e_tgt = m_ma ? PMB_TGT_NONE : PMB_TGT_FLASH0;
        end else if (a <= `PMB_FLASH1_END) e_tgt = PMB_TGT_FLASH1;
        else if (a >= `PMB_BFLASH_BASE && a <= `PMB_BFLASH_END) begin
            e_ext = (m_ma != 0 && m_wide != 0);
            e_tgt = e_ext ? PMB_TGT_NONE : PMB_TGT_BFLASH;
        end else if (a >= `PMB_PRAM_BASE && a <= `PMB_PRAM_END) e_tgt = PMB_TGT_PRAM;
        cmp_val("route.ext", e_ext, route.ext);
        cmp_val("route.reach", e_ext && a <= (m_wide ? `PMB_LIM20 : `PMB_LIM16), route.reach);
        cmp_val("xmem ack", e_ext && a <= (m_wide ? `PMB_LIM20 : `PMB_LIM16), xack);
        if (!e_ext) cmp_val("route.tgt", e_tgt, route.tgt);
    endtask

    // Boundaries of every region, then random addresses over the whole space
    task automatic decode_run();
        for (int i = 0; i < 26; i++) begin
            addr = (i < 14) ? edges[i] : 21'($urandom);
            tick();
            cmp_route(addr);
        end
    endtask

    task automatic write_bit(input logic is_ma, input logic v);
        ma_wr = is_ma;
        mb_wr = ~is_ma;
        ma_d = v;
        mb_d = v;
        tick();
        ma_wr = 1'b0;
        mb_wr = 1'b0;
    endtask

    // Pins settle at the start of reset so the synchronisers are full at release
    task automatic do_reset(input logic s, input logic b, input logic w);
        sec = s;
        boot = b;
        width = w;
        rst_i = 1'b1;
        repeat (5) tick();
        cmp_val("cfg_valid", 0, cfg_o);
        cmp_val("boot_vector reset", `PMB_BOOT_INT, bvec);
        cmp_val("limit reset", `PMB_LIM16, lim);
        rst_i = 1'b0;
        for (int k = 0; k < 8 && cfg_o !== 1'b1; k++) tick();
        repeat (2) tick();
        m_mb = !s;
        m_ext = b && !s;
        m_ma = m_ext;
        m_wide = m_ext && w;
        cmp_val("secured_state", m_mb, mb_o);
        cmp_val("map_select", m_ma, ma_o);
        cmp_val("wide_bus", m_wide, wide_o);
        cmp_val("limit", m_wide ? `PMB_LIM20 : `PMB_LIM16, lim);
        cmp_val("boot_vector", (m_ext && !m_wide) ? `PMB_BOOT_EXT16 : `PMB_BOOT_INT, bvec);
        cmp_val("wdog_vector", (m_ext && !m_wide) ? `PMB_WDOG_EXT16 : `PMB_WDOG_INT, wvec);
        cmp_val("cs_legacy", 1, csl_o);
        cmp_val("flash_secure", s, fsec_o);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard, far beyond the expected run of some 544 cycles
    initial begin
        #(25 * 40000);
        miscompares++;
        close_out();
    end

    // Every strap and security combination, each with its own reset
    initial begin
        {rst_i, sec, boot, width, ma_wr, ma_d, mb_wr, mb_d, addr} = '0;
        rst_i = 1'b1;
        miscompares = 0;
        compares = 0;
        void'($urandom(32'h9eb0));
        for (int c = 0; c < 8; c++) begin
            do_reset(c[2], c[1], c[0]);
            decode_run();
            sec = ~sec;
            repeat (4) tick();
            cmp_val("secured_state held", m_mb, mb_o);
            cmp_val("flash_secure follows", sec, fsec_o);
            write_bit(1'b0, m_mb == 0);
            m_mb = !m_mb;
            cmp_val("secured_state written", m_mb, mb_o);
            cmp_val("flash_secure kept", sec, fsec_o);
            cmp_val("map kept", m_ma, ma_o);
            tick();
            write_bit(1'b1, m_ma == 0);
            if (!c[2]) m_ma = !m_ma;
            cmp_val("map_select written", m_ma, ma_o);
            cmp_val("boot_vector kept", (m_ext && !m_wide) ? `PMB_BOOT_EXT16 : `PMB_BOOT_INT, bvec);
            decode_run();
        end
        close_out();
    end
endmodule
